/* File: hdl/owa_e2_adapt.sv */
// Orderwire to E2 byte adaptation, source and sink directions
`timescale 1ns/10ps
`include "owa_params.svh"
// Functional notes
// - source puts the 64 kbit/s orderwire stream into the outgoing E2 byte
// - source slip buffer is written on the orderwire input clock
// - source buffer is read at the STM-1 frame position and slip decisions
// - positive slip skips one whole octet, once
// - negative slip sends the same octet a second time
// - source slip buffer holds at least two octets
// - sink takes orderwire data from the received E2 byte
// - sink writes extracted bits into its store on the gapped frame clock
// - sink store is read by an evenly spaced 64 kHz clock tracking far rate
// - sink store is deep enough for error-free 4.6 ppm offset
// - sink recovers error-free within about one second after a rate step
// - trail fail raises alarm; all-ONEs within 1 ms, data back within 1 ms
// - all-ONEs output keeps 64 kbit/s within 100 ppm
module owa_e2_adapt
  import owa_pkg::*;
#(
  parameter int SRC_DEPTH = `OWA_SRC_DEPTH,
  parameter int SNK_DEPTH = `OWA_SNK_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic orderwire_clock,
  input wire logic orderwire_data,
  input wire logic line_timing_frame_start,
  output logic [7:0] e2_tx_byte,
  output logic e2_tx_strobe,
  output logic src_slip_pos,
  output logic src_slip_neg,
  input wire logic [7:0] section_access_data,
  input wire logic section_access_frame_start,
  output logic section_access_ready,
  input wire logic trail_signal_fail,
  output logic orderwire_data_out,
  output logic orderwire_clock_out,
  output logic orderwire_frame_start,
  output logic ais_insert_action
);

  // Source fill thresholds keep one whole octet of margin at either end; sink trim thresholds sit one band either side of centre
  localparam int SPW = $clog2(SRC_DEPTH) + 1;
  localparam int NPW = $clog2(SNK_DEPTH) + 1;
  localparam int OCT = `OWA_OCTET_BITS;
  localparam logic [SPW-1:0] SRC_LOW = SPW'(OCT);
  localparam logic [SPW-1:0] SRC_HIGH = SPW'(SRC_DEPTH - OCT);
  localparam logic [SPW-1:0] SRC_FULL = SPW'(SRC_DEPTH);
  localparam logic [NPW-1:0] SNK_OCT = NPW'(OCT);
  localparam logic [NPW-1:0] SNK_CENTER = NPW'(SNK_DEPTH / 2);
  localparam logic [NPW-1:0] SNK_HI = NPW'(SNK_DEPTH / 2 + `OWA_SNK_TRIM_BAND);
  localparam logic [NPW-1:0] SNK_LO = NPW'(SNK_DEPTH / 2 - `OWA_SNK_TRIM_BAND);
  localparam logic [NPW-1:0] SNK_FULL = NPW'(SNK_DEPTH);
  // Divider limits are counts minus one: a half ends when the count reaches them
  localparam logic [9:0] HALF_LIM = 10'(`OWA_OW_HALF_BASE - 1);
  localparam logic [9:0] HALF_ODD = 10'(`OWA_OW_HALF_ODD);

  // All state is one packed struct; the process below fills its next value
  typedef struct packed
  {
    logic [2:0] sync_ck;
    logic [2:0] sync_d;
    logic ck_stable;
    logic [SRC_DEPTH-1:0] src_mem;
    logic [SPW-1:0] src_wr;
    logic [SPW-1:0] src_rd;
    owa_octet_t tx_byte;
    logic tx_strobe;
    logic slip_pos;
    logic slip_neg;
    logic [SNK_DEPTH-1:0] snk_mem;
    logic [NPW-1:0] snk_wr;
    logic [NPW-1:0] snk_rd;
    owa_snk_state_e snk_state;
    logic [9:0] half_cnt;
    logic [1:0] half_ph;
    logic trim_fast;
    logic trim_slow;
    logic [2:0] bit_cnt;
    logic ow_clk;
    logic ow_data;
    logic ow_fs;
    logic ais;
  } owa_top_s;

  owa_top_s st_r;
  owa_top_s st_nxt;
  // Helpers below get a value on every pass of the process, or from the pair buffer
  owa_octet_t buf_data;
  logic buf_valid;
  logic buf_take;
  logic buf_in_ready;
  logic ck_rise;
  logic [SPW-1:0] src_fill;
  logic [NPW-1:0] snk_fill;
  logic [NPW-1:0] snk_rd_eff;
  logic [NPW-2:0] widx;
  logic [9:0] half_limit;

  // Pick one octet out of the source store, first-written bit as MSB
  function automatic owa_octet_t src_octet(input logic [SRC_DEPTH-1:0] mem,
                                           input logic [SPW-1:0] ptr);
    owa_octet_t o;
    logic [SPW-2:0] idx;
    o = '0;
    idx = '0;
    for (int i = 0; i < OCT; i++)
    begin
      idx = ptr[SPW-2:0] + (SPW-1)'(i);
      o[OCT-1-i] = mem[idx];
    end
    return o;
  endfunction : src_octet

  // Received E2 bytes wait here while the sink store is full
  owa_pair_buffer #(
    .W(8)
  ) u_rx_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_data(section_access_data),
    .in_valid(section_access_frame_start),
    .in_ready(buf_in_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_take)
  );

  // Both directions: source pin sync, bit write, octet read per frame, then sink write, divider and alarm
  always_comb
  begin
    st_nxt = st_r;
    buf_take = 1'b0;
    widx = '0;
    snk_rd_eff = st_r.snk_rd;
    half_limit = HALF_LIM;

    // Three-stage sync; only the agreeing later stages are ever looked at
    st_nxt.sync_ck = {st_r.sync_ck[1:0], orderwire_clock};
    st_nxt.sync_d = {st_r.sync_d[1:0], orderwire_data};
    if (st_r.sync_ck[1] == st_r.sync_ck[2])
      st_nxt.ck_stable = st_r.sync_ck[2];
    ck_rise = (st_r.sync_ck[1] == st_r.sync_ck[2]) && st_r.sync_ck[2] && !st_r.ck_stable;

    // Data shares the clock's sync delay, so it is sampled as the edge lands
    src_fill = st_r.src_wr - st_r.src_rd;
    if (ck_rise && (src_fill != SRC_FULL))
    begin
      st_nxt.src_mem[st_r.src_wr[SPW-2:0]] = st_r.sync_d[2];
      st_nxt.src_wr = st_r.src_wr + SPW'(1);
    end

    // One octet per frame slot; fill level chooses normal, skip or repeat
    st_nxt.tx_strobe = 1'b0;
    st_nxt.slip_pos = 1'b0;
    st_nxt.slip_neg = 1'b0;
    if (line_timing_frame_start)
    begin
      st_nxt.tx_strobe = 1'b1;
      if (src_fill < SRC_LOW)
      begin
        st_nxt.slip_neg = 1'b1;
      end
      else if (src_fill > SRC_HIGH)
      begin
        st_nxt.tx_byte = src_octet(st_r.src_mem, st_r.src_rd + SPW'(OCT));
        st_nxt.src_rd = st_r.src_rd + SPW'(2 * OCT);
        st_nxt.slip_pos = 1'b1;
      end
      else
      begin
        st_nxt.tx_byte = src_octet(st_r.src_mem, st_r.src_rd);
        st_nxt.src_rd = st_r.src_rd + SPW'(OCT);
      end
    end

    // Sink write: stall while full, drop the oldest octet only once the
    // pair buffer is also full, so a lasting rate step cannot lock us up
    snk_fill = st_r.snk_wr - st_r.snk_rd;
    if (buf_valid)
    begin
      if (snk_fill <= (SNK_FULL - SNK_OCT))
        buf_take = 1'b1;
      else if (!buf_in_ready)
      begin
        buf_take = 1'b1;
        snk_rd_eff = st_r.snk_rd + SNK_OCT;
      end
    end
    st_nxt.snk_rd = snk_rd_eff;
    if (buf_take)
    begin
      for (int i = 0; i < OCT; i++)
      begin
        widx = st_r.snk_wr[NPW-2:0] + (NPW-1)'(i);
        st_nxt.snk_mem[widx] = buf_data[OCT-1-i];
      end
      st_nxt.snk_wr = st_r.snk_wr + SNK_OCT;
    end

    // Half-period divider: 64 kHz is 156.25 cycles a half, so the first
    // half of every four is one cycle longer and two bits take exactly 625
    // cycles; a plain 156 would run about 0.16 % fast, far outside 100 ppm
    if (10'(st_r.half_ph) < HALF_ODD)
      half_limit = HALF_LIM + 10'd1;
    // The trim moves a half by one cycle only while the store is off centre
    if (st_r.trim_slow)
      half_limit = half_limit + 10'd1;
    else if (st_r.trim_fast)
      half_limit = half_limit - 10'd1;
    st_nxt.half_cnt = st_r.half_cnt + 10'd1;
    if (st_r.half_cnt >= half_limit)
    begin
      st_nxt.half_cnt = '0;
      st_nxt.half_ph = st_r.half_ph + 2'd1;
      st_nxt.ow_clk = !st_r.ow_clk;
      // New bit goes out on the falling edge so the user samples on rising
      if (st_r.ow_clk)
      begin
        st_nxt.bit_cnt = st_r.bit_cnt + 3'd1;
        st_nxt.ow_fs = (st_r.bit_cnt == 3'd0);
        st_nxt.ow_data = 1'b1;
        st_nxt.trim_fast = 1'b0;
        st_nxt.trim_slow = 1'b0;
        if (st_r.snk_state == OWA_SNK_RUN)
        begin
          if (snk_fill != '0)
          begin
            st_nxt.ow_data = st_r.snk_mem[snk_rd_eff[NPW-2:0]];
            st_nxt.ow_fs = (snk_rd_eff[2:0] == 3'd0);
            st_nxt.bit_cnt = snk_rd_eff[2:0] + 3'd1;
            st_nxt.snk_rd = snk_rd_eff + NPW'(1);
            // Rate tracking: nudge one cycle per half while off centre
            st_nxt.trim_fast = (snk_fill > SNK_HI);
            st_nxt.trim_slow = (snk_fill < SNK_LO);
          end
          else
            st_nxt.snk_state = OWA_SNK_FILL;
        end
      end
    end

    // Alarm and refill; refill to half depth takes about half a millisecond
    unique case (st_r.snk_state)
      OWA_SNK_FILL:
      begin
        if (snk_fill >= SNK_CENTER)
          st_nxt.snk_state = OWA_SNK_RUN;
      end
      OWA_SNK_RUN:
      begin
      end
      OWA_SNK_AIS:
      begin
        st_nxt.ow_data = 1'b1;
        st_nxt.snk_rd = st_nxt.snk_wr;
        if (!trail_signal_fail)
          st_nxt.snk_state = OWA_SNK_FILL;
      end
      default:
        st_nxt.snk_state = OWA_SNK_FILL;
    endcase
    // Fail wins over every state so the ones reach the pin on the next edge
    if (trail_signal_fail)
    begin
      st_nxt.snk_state = OWA_SNK_AIS;
      st_nxt.ow_data = 1'b1;
    end
    st_nxt.ais = trail_signal_fail;
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      // The data pin idles at one, the same level as the alarm fill
      st_r.ow_data <= 1'b1;
      st_r.snk_state <= OWA_SNK_FILL;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state flops
  assign e2_tx_byte = st_r.tx_byte;
  assign e2_tx_strobe = st_r.tx_strobe;
  assign src_slip_pos = st_r.slip_pos;
  assign src_slip_neg = st_r.slip_neg;
  assign section_access_ready = buf_in_ready;
  assign orderwire_data_out = st_r.ow_data;
  assign orderwire_clock_out = st_r.ow_clk;
  assign orderwire_frame_start = st_r.ow_fs;
  assign ais_insert_action = st_r.ais;

endmodule : owa_e2_adapt

/* File: hdl/owa_pair_buffer.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module owa_pair_buffer
  import owa_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  typedef struct packed
  {
    logic [W-1:0] slot0;
    logic [W-1:0] slot1;
    logic [1:0] count;
    logic in_ready;
  } owa_pbuf_s;

  owa_pbuf_s st_r;
  owa_pbuf_s st_nxt;
  logic push;
  logic pop;

  // Ready is a flop so the upstream sees a clean level
  assign in_ready = st_r.in_ready;
  assign out_data = st_r.slot0;
  assign out_valid = (st_r.count != 2'd0);

  // Pop first, then place the pushed word behind what is left
  always_comb
  begin
    st_nxt = st_r;
    push = in_valid && st_r.in_ready;
    pop = out_valid && out_ready;
    if (pop)
    begin
      st_nxt.slot0 = st_r.slot1;
      st_nxt.count = st_r.count - 2'd1;
    end
    if (push)
    begin
      if (st_nxt.count == 2'd0)
        st_nxt.slot0 = in_data;
      else
        st_nxt.slot1 = in_data;
      st_nxt.count = st_nxt.count + 2'd1;
    end
    st_nxt.in_ready = (st_nxt.count != 2'd2);
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '{slot0: '0, slot1: '0, count: 2'd0, in_ready: 1'b1};
    else
      st_r <= st_nxt;
  end

endmodule : owa_pair_buffer

/* File: include/owa_params.svh */
// Timing, sizing and threshold constants for the orderwire E2 adaptation
`ifndef OWA_PARAMS_SVH
`define OWA_PARAMS_SVH

`define OWA_REF_CLK_HZ 20000000
`define OWA_OW_RATE_HZ 64000
// Two bit periods hold a whole number of reference cycles, that is four halves
`define OWA_OW_DIV_X2 ((2 * `OWA_REF_CLK_HZ) / `OWA_OW_RATE_HZ)
`define OWA_OW_HALF_BASE (`OWA_OW_DIV_X2 / 4)
`define OWA_OW_HALF_ODD (`OWA_OW_DIV_X2 % 4)
`define OWA_OCTET_BITS 8
`define OWA_SRC_DEPTH 32
`define OWA_SNK_DEPTH 64
`define OWA_SNK_TRIM_BAND 8

`endif

/* File: include/owa_pkg.sv */
// Shared types for the orderwire E2 adaptation
package owa_pkg;

  typedef logic [7:0] owa_octet_t;

  // Sink read side states, Gray along fill -> run -> alarm
  typedef enum logic [1:0]
  {
    OWA_SNK_FILL = 2'b00,
    OWA_SNK_RUN = 2'b01,
    OWA_SNK_AIS = 2'b11
  } owa_snk_state_e;

endpackage : owa_pkg

/* File: tb/owa_e2_adapt_props.sv */
// Port checker for the orderwire E2 adaptation
`timescale 1ns/10ps
module owa_e2_adapt_props
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic line_timing_frame_start,
  input wire logic [7:0] e2_tx_byte,
  input wire logic e2_tx_strobe,
  input wire logic src_slip_pos,
  input wire logic src_slip_neg,
  input wire logic trail_signal_fail,
  input wire logic orderwire_data_out,
  input wire logic orderwire_clock_out,
  input wire logic ais_insert_action
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic clk_q_r;
  logic [9:0] half_r;
  // Half length of the smoothed clock; 64 kHz is 312.5 cycles a bit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_q_r <= 1'b0;
      half_r <= 10'h000;
    end
    else
    begin
      clk_q_r <= orderwire_clock_out;
      half_r <= (orderwire_clock_out != clk_q_r) ? 10'h001 : half_r + 10'h001;
    end
  end
  sequence s_slot;
    line_timing_frame_start ##1 e2_tx_strobe;
  endsequence
  sequence s_alarm;
    $rose(trail_signal_fail) ##1 (ais_insert_action && orderwire_data_out);
  endsequence
  a_strobe_follows: assert property (line_timing_frame_start |-> s_slot)
    else $error("no strobe after slot");
  a_strobe_caused: assert property (e2_tx_strobe |-> $past(line_timing_frame_start))
    else $error("strobe without slot");
  a_byte_held: assert property (!e2_tx_strobe |-> $stable(e2_tx_byte))
    else $error("byte moved between slots");
  a_slip_on_strobe: assert property ((src_slip_pos || src_slip_neg) |->
    (e2_tx_strobe && !(src_slip_pos && src_slip_neg)))
    else $error("slip flag out of place");
  a_repeat_octet: assert property (src_slip_neg |-> $stable(e2_tx_byte))
    else $error("repeat changed byte");
  a_skip_once: assert property (src_slip_pos |=> !src_slip_pos)
    else $error("skip held");
  a_alarm_rise: assert property ($rose(trail_signal_fail) |-> s_alarm)
    else $error("alarm late");
  a_alarm_ones: assert property (ais_insert_action |-> orderwire_data_out)
    else $error("data under alarm");
  a_alarm_clear: assert property (!trail_signal_fail [*2] |-> !ais_insert_action)
    else $error("alarm stuck");
  a_data_on_fall: assert property ($changed(orderwire_data_out) |->
    ($fell(orderwire_clock_out) || ais_insert_action))
    else $error("data moved off clock fall");
  a_clk_half: assert property ((orderwire_clock_out != clk_q_r) |->
    half_r inside {[155:158]})
    else $error("clock half off rate");
  a_clk_alive: assert property (half_r < 10'h0A0)
    else $error("clock stalled");
endmodule : owa_e2_adapt_props

bind owa_e2_adapt owa_e2_adapt_props owa_e2_adapt_props_inst
(
  .ref_clk(ref_clk), .rst_n(rst_n), .line_timing_frame_start(line_timing_frame_start),
  .e2_tx_byte(e2_tx_byte), .e2_tx_strobe(e2_tx_strobe), .src_slip_pos(src_slip_pos),
  .src_slip_neg(src_slip_neg), .trail_signal_fail(trail_signal_fail),
  .orderwire_data_out(orderwire_data_out), .orderwire_clock_out(orderwire_clock_out),
  .ais_insert_action(ais_insert_action)
);

/* File: tb/owa_ow_partner.sv */
// Orderwire supplier: 64 kbit/s stream with its own clock
`timescale 1ns/10ps
module owa_ow_partner
#(
  parameter real HALF_NS = 7812.5
)
(
  input wire logic run,
  output logic ow_clk,
  output logic ow_dat
);
  logic [7:0] oct;
  int bi;
  // Octets count up from one, first bit is the MSB; data moves while clock is low
  initial
  begin
    ow_clk = 1'b0;
    ow_dat = 1'b1;
    oct = 8'h01;
    bi = 7;
    forever
    begin
      if (!run)
        #(HALF_NS) ow_dat = ~ow_dat; // Idle: clock stands, no stale bit
      else
      begin
        ow_dat = oct[bi];
        #(HALF_NS) ow_clk = 1'b1;
        #(HALF_NS) ow_clk = 1'b0;
        oct = (bi == 0) ? oct + 8'h01 : oct;
        bi = (bi == 0) ? 7 : bi - 1;
      end
    end
  end
endmodule : owa_ow_partner

/* File: tb/tb.sv */
// Self-checking bench for the orderwire E2 adaptation
`timescale 1ns/10ps
module tb;
  logic ref_clk, rst_n, ow_clk, ow_dat, ow_run, go, stb, sp, sn;
  logic sa_fs, rdy, tsf, od, oc, ofs, ais, mon_en, mon_have, rdy_low;
  logic [7:0] e2b, sa_data, snk_v, mon_sh, mon_prev;
  int bad_count = 0;
  int checks = 0;
  int mon_cnt, mon_oct, np, nn;

  owa_e2_adapt owa_e2_adapt_inst
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .orderwire_clock(ow_clk), .orderwire_data(ow_dat),
    .line_timing_frame_start(go), .e2_tx_byte(e2b), .e2_tx_strobe(stb),
    .src_slip_pos(sp), .src_slip_neg(sn), .section_access_data(sa_data),
    .section_access_frame_start(sa_fs), .section_access_ready(rdy),
    .trail_signal_fail(tsf), .orderwire_data_out(od), .orderwire_clock_out(oc),
    .orderwire_frame_start(ofs), .ais_insert_action(ais)
  );
  owa_ow_partner owa_ow_partner_inst (.run(ow_run), .ow_clk(ow_clk), .ow_dat(ow_dat));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // Sink octets gathered mid-bit; all-ONEs fill octets are skipped
  always @(posedge oc)
  begin
    mon_sh = {mon_sh[6:0], od};
    mon_cnt = ofs ? 1 : mon_cnt + 1;
    if (mon_cnt == 8 && mon_sh != 8'hFF && mon_en)
    begin
      if (mon_have)
        check(mon_sh, mon_prev + 8'h01);
      mon_prev = mon_sh;
      mon_have = 1'b1;
      mon_oct++;
    end
  end

  // Ready is judged at the falling edge, once the design's updates have landed
  always @(negedge ref_clk)
    if (rdy === 1'b0)
      rdy_low = 1'b1;

  // Frames at a chosen spacing; each octet follows the last by the slip it reports
  task automatic src_run(input int gap, input int n);
    logic [7:0] prev;
    prev = e2b;
    repeat (n)
    begin
      repeat (gap) @(posedge ref_clk);
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(negedge ref_clk);
      check({7'h00, stb}, 8'h01);
      check(e2b, prev + (sp ? 8'h02 : sn ? 8'h00 : 8'h01));
      np += sp;
      nn += sn;
      prev = e2b;
    end
  endtask : src_run

  // One received E2 byte per 125 us frame, the nominal rate
  task automatic snk_feed(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      sa_data <= snk_v;
      sa_fs <= 1'b1;
      @(posedge ref_clk);
      sa_fs <= 1'b0;
      snk_v = snk_v + 8'h01;
      repeat (2498) @(posedge ref_clk);
    end
  endtask : snk_feed

  // Twelve back-to-back bytes, enough that the pair buffer refuses some
  task automatic snk_burst;
    int k;
    int h;
    mon_en = 1'b0;
    rdy_low = 1'b0;
    sa_fs <= 1'b1;
    repeat (12)
    begin
      sa_data <= snk_v;
      snk_v = snk_v + 8'h01;
      @(posedge ref_clk);
    end
    sa_fs <= 1'b0;
    check({7'h00, rdy_low}, 8'h01);
    // Full store: once a bit has gone out, a high half is one cycle short
    repeat (320) @(negedge ref_clk);
    k = 0;
    while (oc === 1'b1 && k < 400)
    begin
      @(negedge ref_clk);
      k++;
    end
    while (oc === 1'b0 && k < 800)
    begin
      @(negedge ref_clk);
      k++;
    end
    h = 0;
    while (oc === 1'b1 && h < 400)
    begin
      @(negedge ref_clk);
      h++;
    end
    check(8'(h), 8'h9B);
  endtask : snk_burst

  // Fail forces ones; on release data must come back inside 1 ms (8 frames)
  task automatic ais_cycle;
    int k;
    tsf <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check({6'h00, ais, od}, 8'h03);
    repeat (3000) @(posedge ref_clk);
    tsf <= 1'b0;
    mon_have = 1'b0;
    mon_oct = 0;
    mon_en = 1'b1;
    k = 0;
    while (mon_oct < 1 && k < 12)
    begin
      snk_feed(1);
      k++;
    end
    check({7'h00, k <= 8}, 8'h01);
    snk_feed(2);
    if (mon_oct < 2)
    begin
      bad_count++;
      print_verdict();
    end
  endtask : ais_cycle

  initial
  begin
    rst_n = 1'b0;
    {ow_run, go, sa_fs, tsf, mon_en, mon_have, rdy_low} = 7'h00;
    sa_data = 8'h00;
    snk_v = 8'h10;
    {mon_cnt, mon_oct, np, nn} = '0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    ow_run <= 1'b1;
    src_run(4000, 6);
    check({7'h00, np > 0}, 8'h01);
    src_run(300, 10);
    check({7'h00, nn > 0}, 8'h01);
    mon_en = 1'b1;
    snk_feed(9);
    check({7'h00, mon_oct > 2}, 8'h01);
    snk_burst();
    ais_cycle();
    print_verdict();
  end
endmodule : tb
